// ===== src/io_port_regs.svh
// Purpose : register map, field positions and reset values of the byte-wide i/o port
// Assumes : 8-bit processor i/o bus with 8-bit addresses
// Notes   : definitions only
`ifndef IO_PORT_REGS_SVH
`define IO_PORT_REGS_SVH

// =====================================================================
// register offsets
`define PIN_DATA_ADDR        8'h38
`define XFER_CLK_SEL_ADDR    8'h3c
`define ALT_FUNC_SEL_ADDR    8'h3d
`define OPEN_DRAIN_SEL_ADDR  8'h3e
`define DIRECTION_SEL_ADDR   8'h3f

// =====================================================================
// field positions and reset values
`define XFER_LO_LSB          0
`define XFER_HI_LSB          4
`define DIRECTION_RESET      8'h00
`define XFER_SEL_RESET       2'h0
`define BYTE_RESET           8'h00
`define SCLK_SECOND_BIT      0
`define SCLK_FIRST_BIT       1
`define PWM_LSB              4

`endif

// ===== src/io_port_pkg.sv
// Purpose : shared types of the byte-wide i/o port
// Assumes : nothing beyond the register header
// Notes   : types only; numbers live in io_port_regs.svh
package io_port_pkg;

  // =====================================================================
  // transfer clock selection
  typedef enum logic [1:0]
  {
    XFER_HALF_CLK = 2'b00,
    XFER_TMR_A1   = 2'b01,
    XFER_TMR_B1   = 2'b10,
    XFER_TMR_B2   = 2'b11
  } xfer_sel_t;

  // processor i/o bus request
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  // alternate output sources
  typedef struct packed
  {
    logic       sclk_first;
    logic       sclk_second;
    logic       sclk_first_int;
    logic       sclk_second_int;
    logic [3:0] pwm;
  } alt_src_t;

  // transfer clock sources
  typedef struct packed
  {
    logic tmr_a1;
    logic tmr_b1;
    logic tmr_b2;
  } tick_src_t;

endpackage : io_port_pkg

// ===== src/nibble_transfer.sv
// Purpose : one nibble of output register, loaded on a rising transfer clock edge
// Assumes : tick sources are synchronous to clock_i
// Notes   : half clock is a free-running divide-by-two toggle kept here
`include "io_port_regs.svh"

module nibble_transfer
  import io_port_pkg::*;
(
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rstn_i,
  // selection and sources
  input  io_port_pkg::xfer_sel_t     sel_i,
  input  io_port_pkg::tick_src_t     tick_i,
  input  wire logic [3:0]            buf_i,
  // registered nibble
  output logic      [3:0]            out_o
);

  // =====================================================================
  // state
  logic       half_q, half_d;
  logic       src_q, src_d;
  logic [3:0] out_q, out_d;
  logic       src_now;

  // pick selected transfer clock
  always_comb
  begin
    case (sel_i)
      XFER_HALF_CLK: src_now = half_q;
      XFER_TMR_A1:   src_now = tick_i.tmr_a1;
      XFER_TMR_B1:   src_now = tick_i.tmr_b1;
      XFER_TMR_B2:   src_now = tick_i.tmr_b2;
      default:       src_now = half_q;
    endcase
  end

  // next values: copy buffer on rising edge of source
  always_comb
  begin
    half_d = ~half_q;
    src_d  = src_now;
    out_d  = out_q;
    if (src_now && !src_q)
    begin
      out_d = buf_i;
    end
  end

  // registers
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      half_q <= 1'b0;
      src_q  <= 1'b0;
      out_q  <= 4'h0;
    end
    else
    begin
      half_q <= half_d;
      src_q  <= src_d;
      out_q  <= out_d;
    end
  end

  assign out_o = out_q;

endmodule : nibble_transfer

// ===== src/io_port.sv
// Purpose : eight-bit general-purpose i/o port with alternate output functions
// Assumes : registers reached over the 8-bit processor i/o bus, one cycle per access
// Notes   : pin inputs pass two flip-flops; pad enables are active low
//
// Notes on behaviour
// - a direction bit of 1 makes the line an output, 0 an input.
// - after reset the direction register is all zeros, so every line is an input except a clock pin forced by a serial port on internal clock.
// - an open-drain bit of 1 makes the output drive low only and float otherwise.
// - the open-drain bit matters only while the line is an output.
// - an open-drain bit of 0 makes the output drive both high and low.
// - an alternate-function bit of 0 lets an output pin carry the port data.
// - alternate bit 0 routes the second serial clock to bit 0, bit 1 the first serial clock to bit 1.
// - alternate bits 4 to 7 route modulator outputs 0 to 3 onto bits 4 to 7.
// - a serial port on internal clock forces its clock pin to output.
// - the control register holds lower nibble select at bits 1:0 and upper at bits 5:4.
// - select 00 is half clock, 01 timer a first, 10 timer b first, 11 timer b second.
// - control bits 3:2 and 7:6 are ignored on write.
// - reset clears both select fields, so both nibbles use half clock.
// - reading the data register returns the live pin levels.
// - writing data loads a buffer, each nibble copied out on its transfer clock rising edge.
// - pins 0 to 3 feed the quadrature decoders, even bits q and odd bits i.
`include "io_port_regs.svh"

module io_port
  import io_port_pkg::*;
(
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rstn_i,
  // processor i/o bus
  input  io_port_pkg::bus_req_t      bus_i,
  output logic      [7:0]            rdata_o,
  // peripheral sources
  input  io_port_pkg::alt_src_t      alt_i,
  input  io_port_pkg::tick_src_t     tick_i,
  // pads
  input  wire logic [7:0]            pin_i,
  output logic      [7:0]            pin_o,
  output logic      [7:0]            pin_oe_n_o,
  // quadrature decoder feeds
  output logic      [1:0]            quad_i_o,
  output logic      [1:0]            quad_q_o
);

  // =====================================================================
  // configuration registers
  logic [7:0] dir_q, dir_d;
  logic [7:0] od_q, od_d;
  logic [7:0] alt_q, alt_d;
  logic [7:0] buf_q, buf_d;
  xfer_sel_t  lo_sel_q, lo_sel_d;
  xfer_sel_t  hi_sel_q, hi_sel_d;
  logic [7:0] rdata_q, rdata_d;

  function automatic logic hit(input bus_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // register writes; non-select control bits are dropped
  always_comb
  begin
    dir_d    = dir_q;
    od_d     = od_q;
    alt_d    = alt_q;
    buf_d    = buf_q;
    lo_sel_d = lo_sel_q;
    hi_sel_d = hi_sel_q;
    if (hit(bus_i, `DIRECTION_SEL_ADDR))
    begin
      dir_d = bus_i.wdata;
    end
    if (hit(bus_i, `OPEN_DRAIN_SEL_ADDR))
    begin
      od_d = bus_i.wdata;
    end
    if (hit(bus_i, `ALT_FUNC_SEL_ADDR))
    begin
      alt_d = bus_i.wdata;
    end
    if (hit(bus_i, `PIN_DATA_ADDR))
    begin
      buf_d = bus_i.wdata;
    end
    if (hit(bus_i, `XFER_CLK_SEL_ADDR))
    begin
      lo_sel_d = xfer_sel_t'(bus_i.wdata[`XFER_LO_LSB +: 2]);
      hi_sel_d = xfer_sel_t'(bus_i.wdata[`XFER_HI_LSB +: 2]);
    end
  end

  // =====================================================================
  // pin synchroniser
  logic [7:0] sync1_q, sync2_q;

  // read data: live pins only, write-only registers read zero
  always_comb
  begin
    rdata_d = `BYTE_RESET;
    if (bus_i.rd && (bus_i.addr == `PIN_DATA_ADDR))
    begin
      rdata_d = sync2_q;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dir_q    <= `DIRECTION_RESET;
      od_q     <= `BYTE_RESET;
      alt_q    <= `BYTE_RESET;
      buf_q    <= `BYTE_RESET;
      lo_sel_q <= xfer_sel_t'(`XFER_SEL_RESET);
      hi_sel_q <= xfer_sel_t'(`XFER_SEL_RESET);
      rdata_q  <= `BYTE_RESET;
      sync1_q  <= `BYTE_RESET;
      sync2_q  <= `BYTE_RESET;
    end
    else
    begin
      dir_q    <= dir_d;
      od_q     <= od_d;
      alt_q    <= alt_d;
      buf_q    <= buf_d;
      lo_sel_q <= lo_sel_d;
      hi_sel_q <= hi_sel_d;
      rdata_q  <= rdata_d;
      sync1_q  <= pin_i;
      sync2_q  <= sync1_q;
    end
  end

  // =====================================================================
  // output register, one transfer unit per nibble
  logic [7:0] port_out;

  nibble_transfer u_lo
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .sel_i   (lo_sel_q),
    .tick_i  (tick_i),
    .buf_i   (buf_q[3:0]),
    .out_o   (port_out[3:0])
  );

  nibble_transfer u_hi
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .sel_i   (hi_sel_q),
    .tick_i  (tick_i),
    .buf_i   (buf_q[7:4]),
    .out_o   (port_out[7:4])
  );

  // =====================================================================
  // pad drive; registered so pads come straight from flip-flops
  logic [7:0] pin_q, pin_d;
  logic [7:0] oe_n_q, oe_n_d;
  logic [1:0] qi_q, qi_d, qq_q, qq_d;

  always_comb
  begin
    logic [7:0] eff_dir;
    logic [7:0] level;
    eff_dir = dir_q;
    level   = port_out;
    // internal serial clock forces its pin to output
    if (alt_i.sclk_second_int)
    begin
      eff_dir[`SCLK_SECOND_BIT] = 1'b1;
    end
    if (alt_i.sclk_first_int)
    begin
      eff_dir[`SCLK_FIRST_BIT] = 1'b1;
    end
    // alternate sources replace port data only, never the direction
    if (alt_q[`SCLK_SECOND_BIT])
    begin
      level[`SCLK_SECOND_BIT] = alt_i.sclk_second;
    end
    if (alt_q[`SCLK_FIRST_BIT])
    begin
      level[`SCLK_FIRST_BIT] = alt_i.sclk_first;
    end
    for (int b = 0; b < 4; b++)
    begin
      if (alt_q[`PWM_LSB + b])
      begin
        level[`PWM_LSB + b] = alt_i.pwm[b];
      end
    end
    for (int b = 0; b < 8; b++)
    begin
      pin_d[b] = od_q[b] ? 1'b0 : level[b];
      // open drain enables only for a low; input bits ignore od
      oe_n_d[b] = !(eff_dir[b] && (!od_q[b] || !level[b]));
    end
    // even pins q, odd pins i
    qq_d = {sync2_q[2], sync2_q[0]};
    qi_d = {sync2_q[3], sync2_q[1]};
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_q  <= `BYTE_RESET;
      oe_n_q <= 8'hff;
      qi_q   <= 2'h0;
      qq_q   <= 2'h0;
    end
    else
    begin
      pin_q  <= pin_d;
      oe_n_q <= oe_n_d;
      qi_q   <= qi_d;
      qq_q   <= qq_d;
    end
  end

  assign rdata_o    = rdata_q;
  assign pin_o      = pin_q;
  assign pin_oe_n_o = oe_n_q;
  assign quad_i_o   = qi_q;
  assign quad_q_o   = qq_q;

endmodule : io_port

// ===== dv/motor_side_model.sv
// Purpose : far-side circuitry on the port pads
// Assumes : every pad has a pull-up
// Notes   : a far side that fights a driven pad is not modelled
module motor_side_model
(
  // design pads
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_n_o,
  // far-side drive
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  // resolved level
  output logic      [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pads take the far-side drive where enabled, else the pull-up level, never keep the last value
  assign level_o = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & (~ext_en_i | ext_val_i));
endmodule : motor_side_model

// ===== dv/io_port_checker.sv
// Purpose : pad and bus checks of the byte-wide i/o port
// Assumes : a write settles at the pads within three quiet cycles
// Notes   : write-only registers are shadowed from the bus
`include "io_port_regs.svh"
module io_port_checker
  import io_port_pkg::*;
(
  // clock, reset and bus
  input  wire logic            clock_i,
  input  wire logic            rstn_i,
  input  io_port_pkg::bus_req_t bus_i,
  input  wire logic [7:0]      rdata_o,
  // sources and pads
  input  io_port_pkg::alt_src_t alt_i,
  input  wire logic [7:0]      pin_i,
  input  wire logic [7:0]      pin_o,
  input  wire logic [7:0]      pin_oe_n_o,
  input  wire logic [1:0]      quad_i_o,
  input  wire logic [1:0]      quad_q_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dir_q, od_q, alt_q, pin_q, dir_e, val_e, sel_e;
  logic [2:0] wq_q, pq_q;
  alt_src_t   src_q;
  wire        ok = wq_q > 3'h2;

  // ==========
  // shadows; quiet counters keep checks off while a change ripples
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {dir_q, od_q, alt_q, pin_q, wq_q, pq_q} <= '0;
      src_q <= '0;
    end
    else
    begin
      src_q <= alt_i;
      pin_q <= pin_i;
      wq_q <= bus_i.wr ? 3'h0 : wq_q + 3'(wq_q != 3'h7);
      pq_q <= (pin_i != pin_q) ? 3'h0 : pq_q + 3'(pq_q != 3'h7);
      if (bus_i.wr && bus_i.addr == `DIRECTION_SEL_ADDR)
        dir_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == `OPEN_DRAIN_SEL_ADDR)
        od_q <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == `ALT_FUNC_SEL_ADDR)
        alt_q <= bus_i.wdata;
    end
  end

  // effective direction, alternate values and routed bits
  assign dir_e = dir_q | {6'h00, src_q.sclk_first_int, src_q.sclk_second_int};
  assign val_e = {src_q.pwm, 2'h0, src_q.sclk_first, src_q.sclk_second};
  assign sel_e = alt_q & dir_e & ~od_q & 8'hf3;

  // ==========
  // assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  reset_inputs_a: assert property ($rose(rstn_i) |-> pin_oe_n_o == 8'hff)
    else $error("pad enabled at reset exit");
  input_float_a: assert property (ok |-> (pin_oe_n_o | dir_e) == 8'hff)
    else $error("input pad driven");
  push_pull_a: assert property (ok |-> (pin_oe_n_o & dir_e & ~od_q) == 8'h00)
    else $error("output pad not driven");
  drain_low_a: assert property (ok |-> (pin_o & dir_e & od_q) == 8'h00)
    else $error("open drain drives high");
  alt_route_a: assert property (ok |-> ((pin_o ^ val_e) & sel_e) == 8'h00)
    else $error("alternate source missing");
  read_gate_a: assert property (!$past(bus_i.rd && bus_i.addr == `PIN_DATA_ADDR)
    |-> rdata_o == 8'h00) else $error("read data not zero");
  pin_read_a: assert property (bus_i.rd && bus_i.addr == `PIN_DATA_ADDR && pq_q > 3'h3
    && $stable(pin_i) |=> rdata_o == $past(pin_i)) else $error("pin read wrong");
  quad_map_a: assert property (pq_q > 3'h4 && $stable(pin_i)
    |-> {quad_i_o, quad_q_o} == {pin_i[3], pin_i[1], pin_i[2], pin_i[0]}) else $error("quad feed wrong");
endmodule : io_port_checker

bind io_port io_port_checker chk (.clock_i, .rstn_i, .bus_i, .rdata_o, .alt_i, .pin_i, .pin_o,
  .pin_oe_n_o, .quad_i_o, .quad_q_o);

// ===== dv/io_port_tb.sv
// Purpose : directed register and pad tests of the byte-wide i/o port
// Assumes : far-side model resolves every pad
// Notes   : fixed waits only where a nibble must hold or pads settle
`include "io_port_regs.svh"
module io_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import io_port_pkg::*;
  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  bus_req_t   bus_i = '0;
  alt_src_t   alt_i = '0;
  tick_src_t  tick_i = '0;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00, old, v, pin_i, pin_o, pin_oe_n_o, rdata_o;
  logic [1:0] quad_i_o, quad_q_o;
  int         n_mismatch = 0, n_checks = 0, lo;

  // clock of 4 ns
  always #2 clock_i = ~clock_i;

  // design and far side
  io_port uut (.clock_i, .rstn_i, .bus_i, .rdata_o, .alt_i, .tick_i, .pin_i, .pin_o, .pin_oe_n_o,
    .quad_i_o, .quad_q_o);
  motor_side_model far (.pin_o, .pin_oe_n_o, .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));

  // ==========
  // tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    bus_i <= '0;
  endtask : wr
  // pads reach the read path two cycles late, so let them settle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    repeat (3) @(posedge clock_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    bus_i <= '0;
    #1;
    chk8(rdata_o, exp);
  endtask : rd
  task automatic tick(input logic [2:0] m);
    @(posedge clock_i);
    tick_i <= tick_src_t'(m);
    @(posedge clock_i);
    tick_i <= '0;
  endtask : tick
  // bounded wait for the pads, a hang ends the run
  task automatic chk_pin(input logic [7:0] exp);
    for (int i = 0; i < 8 && pin_o !== exp; i++)
      @(posedge clock_i);
    #1;
    chk8(pin_o, exp);
    if (pin_o !== exp)
      final_report();
  endtask : chk_pin
  task automatic settle;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : settle

  // ==========
  // tests
  initial
  begin
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    #1;
    chk8(pin_oe_n_o, 8'hff);
    rd(`PIN_DATA_ADDR, 8'hff);
    rd(`DIRECTION_SEL_ADDR, 8'h00);
    $display("reset test done");
    wr(`DIRECTION_SEL_ADDR, 8'hff);
    wr(`PIN_DATA_ADDR, 8'ha5);
    wr(8'h39, 8'h00);
    chk_pin(8'ha5);
    chk8(pin_oe_n_o, 8'h00);
    rd(`PIN_DATA_ADDR, 8'ha5);
    $display("output test done");
    old = 8'ha5;
    for (int s = 1; s < 4; s++)
    begin
      lo = s % 3 + 1;
      v = {4'(s), 4'(15 - s)};
      wr(`XFER_CLK_SEL_ADDR, {2'b11, 2'(s), 2'b11, 2'(lo)});
      wr(`PIN_DATA_ADDR, v);
      settle();
      chk8(pin_o, old);
      tick(3'(4 >> (s - 1)));
      chk_pin({v[7:4], old[3:0]});
      tick(3'(4 >> (lo - 1)));
      chk_pin(v);
      old = v;
    end
    $display("transfer clock test done");
    wr(`XFER_CLK_SEL_ADDR, 8'h00);
    wr(`OPEN_DRAIN_SEL_ADDR, 8'h0f);
    wr(`PIN_DATA_ADDR, 8'h35);
    // the drain bits already force the low nibble to zero, so let the new data land first
    settle();
    chk_pin(8'h30);
    chk8(pin_oe_n_o, 8'h05);
    rd(`PIN_DATA_ADDR, 8'h35);
    wr(`OPEN_DRAIN_SEL_ADDR, 8'hff);
    wr(`DIRECTION_SEL_ADDR, 8'h0f);
    ext_en <= 8'hf0;
    ext_val <= 8'h60;
    settle();
    chk8(pin_oe_n_o, 8'hf5);
    rd(`PIN_DATA_ADDR, 8'h65);
    $display("open drain test done");
    wr(`DIRECTION_SEL_ADDR, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'h06;
    settle();
    chk8({4'h0, quad_i_o, quad_q_o}, 8'h06);
    $display("quadrature test done");
    ext_en <= 8'h00;
    wr(`OPEN_DRAIN_SEL_ADDR, 8'h00);
    wr(`PIN_DATA_ADDR, 8'h0c);
    wr(`ALT_FUNC_SEL_ADDR, 8'hff);
    wr(`DIRECTION_SEL_ADDR, 8'hff);
    alt_i <= '{sclk_first: 1'b1, sclk_second: 1'b0, sclk_first_int: 1'b0, sclk_second_int: 1'b0, pwm: 4'h9};
    chk_pin(8'h9e);
    wr(`DIRECTION_SEL_ADDR, 8'h00);
    alt_i <= '{sclk_first: 1'b0, sclk_second: 1'b0, sclk_first_int: 1'b1, sclk_second_int: 1'b0, pwm: 4'h9};
    settle();
    chk8(pin_oe_n_o, 8'hfd);
    rd(`PIN_DATA_ADDR, 8'hfd);
    $display("alternate test done");
    final_report();
  end
endmodule : io_port_tb
